// >>> core/drmf_pkg.sv
// shared types and constants of the domain routing message framer
package drmf_pkg;
  // buffering between element source and sequencer
  localparam int FIFO_DEPTH = 16;
  localparam int ELEM_W = 25;
  // octet counts of each emitted field group
  localparam logic [2:0] LEN_SEQ = 3'h2; // source_sequence
  localparam logic [2:0] LEN_CNT = 3'h1; // any 8-bit count
  localparam logic [2:0] LEN_ID = 3'h1; // lone node_identifier or info octet
  localparam logic [2:0] LEN_TRI = 3'h3; // node_identifier plus 16-bit word
  localparam logic [2:0] LEN_SC = 3'h7; // security_controller id plus registration id
  // shift buffer width: the longest group, in bits
  localparam int SH_W = 56;
  // sequencer states, one-hot
  typedef enum logic [10:0] {
    S_IDLE = 11'h001, // waiting for a start
    S_SEQ = 11'h002, // backup: source_sequence
    S_BINFO = 11'h004, // backup: info octets
    S_ACNT = 11'h008, // routing: ack_request_count
    S_AENT = 11'h010, // routing: acknowledgement entries
    S_NCNT = 11'h020, // routing: node_record_count
    S_RHDR = 11'h040, // routing: record id and size
    S_RINFO = 11'h080, // routing: record info octets
    S_KCNT = 11'h100, // routing: resigned_count
    S_KID = 11'h200, // routing: resigned identifiers
    S_SC = 11'h400 // routing: security_controller
  } drmf_state_t;
  // one element from the record source
  typedef struct packed {
    logic last; // ends backup info
    logic [7:0] id; // node_identifier
    logic [15:0] word; // sequence, size, or info octet in [7:0]
  } drmf_elem_t;
  // per-message configuration, taken at start
  typedef struct packed {
    logic routing; // 1: routing_change_message, 0: backup_update_message
    logic secure; // security_controller field present
    logic sc_present; // controller exists, else zeros
    logic [7:0] ack_count; // m
    logic [7:0] rec_count; // n, domain master included
    logic [7:0] res_count; // k
    logic [15:0] src_seq; // source_sequence
    logic [7:0] sc_id; // controller node_identifier
    logic [47:0] sc_registration_identifier; // controller registration_identifier
  } drmf_cfg_t;
  // one payload octet on the output
  typedef struct packed {
    logic [7:0] data; // payload octet
    logic last; // last octet of the message
    logic seg_end; // last octet of a segment
    logic [7:0] seg_num; // segment number of this octet
  } drmf_octet_t;
endpackage

// >>> core/drmf_framer.sv
// element fifo and payload sequencer of the domain routing message framer
// Function
// - backup update sent on each topology change
// - backup payload opens with 16-bit source_sequence
// - backup info field follows, variable length
// - routing message length follows node content
// - messages split into numbered segments, reassembled
// - records over all segments equal reported total; node_record_count still counts a dropped empty record
// - only non-empty routing records are emitted
// - record carries address table and route tuples
// - resigned nodes since last message listed
// - current security_controller identity carried
// - full and fractional reports share one layout
// - octet zero holds 8-bit ack_request_count
// - each ack: node_identifier then 16-bit sequence
// - node_record_count follows acknowledgement list
// - record: identifier, 16-bit size, then info
// - resigned_count then resigned node identifiers
// - record count includes domain master itself
// - no resigned nodes gives zero, empty list
// - controller: 8-bit id, 48-bit registration id
`timescale 1ns/1ps
`default_nettype none

module drmf_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
) (
  input wire logic core_clk_i,
  input wire logic reset_i,
  input wire logic in_valid_i,
  output logic in_ready_o,
  input wire logic [WIDTH-1:0] in_data_i,
  output logic out_valid_o,
  input wire logic out_ready_i,
  output logic [WIDTH-1:0] out_data_o
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_reg [DEPTH]; // storage words
  logic [AW-1:0] wr_reg; // write index
  logic [AW-1:0] rd_reg; // read index
  logic [AW:0] cnt_reg; // occupancy
  logic [AW:0] cnt_next;
  logic rdy_reg; // registered not-full
  wire push = in_valid_i && rdy_reg;
  wire pop = out_valid_o && out_ready_i;

  // occupancy after this cycle
  always_comb begin
    cnt_next = cnt_reg;
    if (push && !pop) begin
      cnt_next = cnt_reg + 1'b1;
    end else if (pop && !push) begin
      cnt_next = cnt_reg - 1'b1;
    end
  end

  assign in_ready_o = rdy_reg;
  assign out_valid_o = cnt_reg != '0;
  assign out_data_o = mem_reg[rd_reg];

  // pointers and count
  always_ff @(posedge core_clk_i or posedge reset_i) begin
    if (reset_i) begin
      wr_reg <= '0;
      rd_reg <= '0;
      cnt_reg <= '0;
      rdy_reg <= 1'b0;
    end else begin
      if (push) begin
        wr_reg <= wr_reg + 1'b1;
      end
      if (pop) begin
        rd_reg <= rd_reg + 1'b1;
      end
      cnt_reg <= cnt_next;
      rdy_reg <= cnt_next != (AW+1)'(DEPTH);
    end
  end

  // storage write, no reset needed for data
  always_ff @(posedge core_clk_i) begin
    if (push) begin
      mem_reg[wr_reg] <= in_data_i;
    end
  end
endmodule

module drmf_framer (
  input wire logic core_clk_i,
  input wire logic reset_i,
  input wire logic start_i,
  input wire drmf_pkg::drmf_cfg_t cfg_i,
  input wire logic [15:0] seg_len_i,
  input wire logic elem_valid_i,
  output logic elem_ready_o,
  input wire drmf_pkg::drmf_elem_t elem_i,
  output logic out_valid_o,
  input wire logic out_ready_i,
  output drmf_pkg::drmf_octet_t out_o,
  output logic busy_o,
  output logic error_o
);
  drmf_pkg::drmf_state_t st_reg, st_next; // sequencer state
  drmf_pkg::drmf_cfg_t cfg_reg, cfg_next; // message in progress
  logic [drmf_pkg::SH_W-1:0] sh_reg, sh_next; // octets waiting to go
  logic [2:0] cnt_reg, cnt_next; // octets left in buffer
  logic lastp_reg, lastp_next; // buffer ends the message
  logic [7:0] rem_reg, rem_next; // items left in a list
  logic [15:0] len_reg, len_next; // info octets left in a record
  logic err_reg, err_next; // sticky empty-record fault
  logic ov_reg; // output octet valid
  drmf_pkg::drmf_octet_t od_reg; // output octet
  logic [15:0] pos_reg; // octet position in segment
  logic [7:0] seg_reg; // current segment number
  logic busy_reg;
  logic f_valid, f_pop;
  drmf_pkg::drmf_elem_t f_data;
  logic [drmf_pkg::ELEM_W-1:0] f_raw;

  // element buffer; its ready stalls the source
  drmf_fifo #(.WIDTH(drmf_pkg::ELEM_W), .DEPTH(drmf_pkg::FIFO_DEPTH)) u_fifo (
    .core_clk_i(core_clk_i),
    .reset_i(reset_i),
    .in_valid_i(elem_valid_i),
    .in_ready_o(elem_ready_o),
    .in_data_i(elem_i),
    .out_valid_o(f_valid),
    .out_ready_i(f_pop),
    .out_data_o(f_raw)
  );
  assign f_data = drmf_pkg::drmf_elem_t'(f_raw);

  // shifter hands an octet over when the output slot frees
  wire sh_pop = (cnt_reg != 3'h0) && (!ov_reg || out_ready_i);
  // a new field group may load only into an empty buffer
  wire can_load = cnt_reg == 3'h0;
  wire take = can_load && f_valid;
  wire oct_last = lastp_reg && (cnt_reg == 3'h1);
  // segment closes at its length or at message end
  wire seg_full = (seg_len_i != 16'h0000) && (pos_reg == seg_len_i - 16'h0001);
  wire seg_end = oct_last || seg_full;
  // end of the routing message after the resigned list
  wire tail_sc = cfg_reg.secure;
  wire [55:0] sc_word = cfg_reg.sc_present ? {cfg_reg.sc_id, cfg_reg.sc_registration_identifier} : 56'h0;
  wire [15:0] rec_size = f_data.word;

  // sequencer: picks the next field group in message order
  always_comb begin
    st_next = st_reg;
    cfg_next = cfg_reg;
    sh_next = sh_reg;
    cnt_next = cnt_reg;
    lastp_next = lastp_reg;
    rem_next = rem_reg;
    len_next = len_reg;
    err_next = err_reg;
    f_pop = 1'b0;
    // drain one octet, highest index first
    if (sh_pop) begin
      sh_next = {sh_reg[47:0], 8'h00};
      cnt_next = cnt_reg - 3'h1;
    end
    if (can_load) begin
      lastp_next = 1'b0;
      unique case (st_reg)
        drmf_pkg::S_IDLE: begin
          // a start picks the message kind
          if (start_i) begin
            cfg_next = cfg_i;
            err_next = 1'b0;
            st_next = cfg_i.routing ? drmf_pkg::S_ACNT : drmf_pkg::S_SEQ;
          end
        end
        drmf_pkg::S_SEQ: begin
          // backup payload opens with the forwarded sequence
          sh_next = {cfg_reg.src_seq, 40'h0};
          cnt_next = drmf_pkg::LEN_SEQ;
          st_next = drmf_pkg::S_BINFO;
        end
        drmf_pkg::S_BINFO: begin
          // info octets copied until the marked last one
          if (f_valid) begin
            f_pop = 1'b1;
            sh_next = {f_data.word[7:0], 48'h0};
            cnt_next = drmf_pkg::LEN_ID;
            if (f_data.last) begin
              lastp_next = 1'b1;
              st_next = drmf_pkg::S_IDLE;
            end
          end
        end
        drmf_pkg::S_ACNT: begin
          // octet zero, same layout for every report
          sh_next = {cfg_reg.ack_count, 48'h0};
          cnt_next = drmf_pkg::LEN_CNT;
          rem_next = cfg_reg.ack_count;
          st_next = (cfg_reg.ack_count != 8'h00) ? drmf_pkg::S_AENT : drmf_pkg::S_NCNT;
        end
        drmf_pkg::S_AENT: begin
          // three octets per acknowledgement
          if (take) begin
            f_pop = 1'b1;
            sh_next = {f_data.id, f_data.word, 32'h0};
            cnt_next = drmf_pkg::LEN_TRI;
            rem_next = rem_reg - 8'h01;
            if (rem_reg == 8'h01) begin
              st_next = drmf_pkg::S_NCNT;
            end
          end
        end
        drmf_pkg::S_NCNT: begin
          // count supplied with the domain master included
          sh_next = {cfg_reg.rec_count, 48'h0};
          cnt_next = drmf_pkg::LEN_CNT;
          rem_next = cfg_reg.rec_count;
          st_next = (cfg_reg.rec_count != 8'h00) ? drmf_pkg::S_RHDR : drmf_pkg::S_KCNT;
        end
        drmf_pkg::S_RHDR: begin
          if (take) begin
            f_pop = 1'b1;
            rem_next = rem_reg - 8'h01;
            if (rec_size == 16'h0000) begin
              // empty record dropped and flagged
              err_next = 1'b1;
              if (rem_reg == 8'h01) begin
                st_next = drmf_pkg::S_KCNT;
              end
            end else begin
              // identifier and size ahead of the info octets
              sh_next = {f_data.id, rec_size, 32'h0};
              cnt_next = drmf_pkg::LEN_TRI;
              len_next = rec_size;
              st_next = drmf_pkg::S_RINFO;
            end
          end
        end
        drmf_pkg::S_RINFO: begin
          // address table and route tuples pass as octets
          if (take) begin
            f_pop = 1'b1;
            sh_next = {f_data.word[7:0], 48'h0};
            cnt_next = drmf_pkg::LEN_ID;
            len_next = len_reg - 16'h0001;
            if (len_reg == 16'h0001) begin
              st_next = (rem_reg == 8'h00) ? drmf_pkg::S_KCNT : drmf_pkg::S_RHDR;
            end
          end
        end
        drmf_pkg::S_KCNT: begin
          // zero resigned gives a bare count
          sh_next = {cfg_reg.res_count, 48'h0};
          cnt_next = drmf_pkg::LEN_CNT;
          rem_next = cfg_reg.res_count;
          if (cfg_reg.res_count != 8'h00) begin
            st_next = drmf_pkg::S_KID;
          end else if (tail_sc) begin
            st_next = drmf_pkg::S_SC;
          end else begin
            lastp_next = 1'b1;
            st_next = drmf_pkg::S_IDLE;
          end
        end
        drmf_pkg::S_KID: begin
          // one identifier per resigned node
          if (take) begin
            f_pop = 1'b1;
            sh_next = {f_data.id, 48'h0};
            cnt_next = drmf_pkg::LEN_ID;
            rem_next = rem_reg - 8'h01;
            if (rem_reg == 8'h01) begin
              lastp_next = !tail_sc;
              st_next = tail_sc ? drmf_pkg::S_SC : drmf_pkg::S_IDLE;
            end
          end
        end
        drmf_pkg::S_SC: begin
          // controller identity closes a secure message
          sh_next = sc_word;
          cnt_next = drmf_pkg::LEN_SC;
          lastp_next = 1'b1;
          st_next = drmf_pkg::S_IDLE;
        end
        default: begin
          // illegal code: back to idle
          st_next = drmf_pkg::S_IDLE;
        end
      endcase
    end
  end

  // sequencer registers
  always_ff @(posedge core_clk_i or posedge reset_i) begin
    if (reset_i) begin
      st_reg <= drmf_pkg::S_IDLE;
      cfg_reg <= '0;
      sh_reg <= '0;
      cnt_reg <= 3'h0;
      lastp_reg <= 1'b0;
      rem_reg <= 8'h00;
      len_reg <= 16'h0000;
      err_reg <= 1'b0;
      busy_reg <= 1'b0;
    end else begin
      st_reg <= st_next;
      cfg_reg <= cfg_next;
      sh_reg <= sh_next;
      cnt_reg <= cnt_next;
      lastp_reg <= lastp_next;
      rem_reg <= rem_next;
      len_reg <= len_next;
      err_reg <= err_next;
      busy_reg <= (st_next != drmf_pkg::S_IDLE) || (cnt_next != 3'h0) || sh_pop || ov_reg;
    end
  end

  // output slot and segment numbering
  always_ff @(posedge core_clk_i or posedge reset_i) begin
    if (reset_i) begin
      ov_reg <= 1'b0;
      od_reg <= '0;
      pos_reg <= 16'h0000;
      seg_reg <= 8'h00;
    end else begin
      if (sh_pop) begin
        ov_reg <= 1'b1;
        od_reg <= '{data: sh_reg[55:48], last: oct_last, seg_end: seg_end, seg_num: seg_reg};
        pos_reg <= seg_end ? 16'h0000 : pos_reg + 16'h0001;
        seg_reg <= oct_last ? 8'h00 : (seg_end ? seg_reg + 8'h01 : seg_reg);
      end else if (out_ready_i) begin
        ov_reg <= 1'b0;
      end
    end
  end

  assign out_valid_o = ov_reg;
  assign out_o = od_reg;
  assign busy_o = busy_reg;
  assign error_o = err_reg;
endmodule

`default_nettype wire

// >>> testbench/drmf_framer_asserts.sv
// port assertions of the domain routing message framer
`timescale 1ns/1ps
`default_nettype none
module drmf_framer_asserts (
  input wire logic core_clk_i,
  input wire logic reset_i,
  input wire logic start_i,
  input wire drmf_pkg::drmf_cfg_t cfg_i,
  input wire logic [15:0] seg_len_i,
  input wire logic elem_valid_i,
  input wire logic elem_ready_o,
  input wire drmf_pkg::drmf_elem_t elem_i,
  input wire logic out_valid_o,
  input wire logic out_ready_i,
  input wire drmf_pkg::drmf_octet_t out_o,
  input wire logic busy_o,
  input wire logic error_o
);
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (reset_i);
  wire take = out_valid_o && out_ready_i; // octet accepted
  wire go = start_i && !busy_o; // start taken while idle
  logic [15:0] pos_reg; // octets taken in current segment
  // segment position counter
  always_ff @(posedge core_clk_i or posedge reset_i) begin
    if (reset_i) pos_reg <= 16'h0000;
    else if (take) pos_reg <= out_o.seg_end ? 16'h0000 : pos_reg + 16'h0001;
  end
  a_octet_held: assert property (out_valid_o && !out_ready_i |=> out_valid_o && $stable(out_o))
    else $error("octet changed before taken");
  a_start_busy: assert property (go |=> busy_o) else $error("busy missing after start");
  a_first_octet: assert property (go |-> ##[1:6] out_valid_o)
    else $error("no first octet after start");
  a_error_cleared: assert property (go |=> !error_o) else $error("error not cleared");
  a_valid_busy: assert property (out_valid_o |-> busy_o) else $error("octet while idle");
  a_last_seg_end: assert property (out_valid_o && out_o.last |-> out_o.seg_end)
    else $error("last without segment end");
  a_segnum_reset: assert property (take && out_o.last |=> !out_valid_o || out_o.seg_num == 8'h00)
    else $error("segment number not restarted");
  a_segnum_step: assert property (take && out_o.seg_end && !out_o.last |=>
    !out_valid_o || out_o.seg_num == $past(out_o.seg_num) + 8'h01)
    else $error("segment number not stepped");
  a_busy_ends: assert property (take && out_o.last |-> ##[1:3] !busy_o)
    else $error("busy stuck after last");
  a_seg_length: assert property (out_valid_o && seg_len_i != 16'h0000 |->
    out_o.seg_end == (out_o.last || pos_reg == seg_len_i - 16'h0001))
    else $error("segment end misplaced");
  c_segmented: cover property (take && out_o.seg_end && !out_o.last);
  c_stalled: cover property (out_valid_o && !out_ready_i);
  c_error: cover property ($rose(error_o));
endmodule
bind drmf_framer drmf_framer_asserts u_asserts (.core_clk_i(core_clk_i), .reset_i(reset_i),
  .start_i(start_i), .cfg_i(cfg_i), .seg_len_i(seg_len_i), .elem_valid_i(elem_valid_i),
  .elem_ready_o(elem_ready_o), .elem_i(elem_i), .out_valid_o(out_valid_o),
  .out_ready_i(out_ready_i), .out_o(out_o), .busy_o(busy_o), .error_o(error_o));
`default_nettype wire

// >>> testbench/drmf_sink.sv
// octet sink standing for the receiving node
`timescale 1ns/1ps
`default_nettype none
module drmf_sink (
  input wire logic core_clk_i,
  input wire logic reset_i,
  input wire logic stall_i,
  input wire logic out_valid_i,
  input wire drmf_pkg::drmf_octet_t oct_i,
  output logic out_ready_o,
  output logic [15:0] seg_cnt_o
);
  int seed = 67; // stall pattern seed
  initial begin
    out_ready_o = 1'b0;
    seg_cnt_o = 16'h0000;
  end
  // ready drops at random while stalling
  always @(posedge core_clk_i) begin
    #1 out_ready_o = !reset_i && (!stall_i || $random(seed) % 2 == 0);
  end
  // segment count: one count per finished segment, octet data not kept or checked
  always @(posedge core_clk_i) begin
    if (out_valid_i && out_ready_o && oct_i.seg_end) seg_cnt_o <= seg_cnt_o + 16'h0001;
  end
endmodule
`default_nettype wire

// >>> testbench/drmf_framer_test.sv
// self-checking bench of the domain routing message framer
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) begin check_count++; if ((g) !== (e)) begin err_count++; \
  $display("mismatch %s expected %0h seen %0h", n, e, g); end end
module drmf_framer_test;
  logic core_clk_i = 1'b0;
  logic reset_i = 1'b1;
  logic start_i = 1'b0;
  drmf_pkg::drmf_cfg_t cfg_i = '0;
  logic [15:0] seg_len_i = 16'h0000;
  logic elem_valid_i = 1'b0;
  drmf_pkg::drmf_elem_t elem_i = '0;
  logic stall = 1'b0; // sink stalls at random
  logic elem_ready_o, out_valid_o, out_ready_i, busy_o, error_o;
  drmf_pkg::drmf_octet_t out_o;
  logic [15:0] seg_cnt; // segments seen by the sink
  logic [7:0] e_d;
  logic e_l, e_se;
  int err_count = 0;
  int check_count = 0;
  int seed = 67;
  int acc = 0; // elements taken
  int pos = 0; // model octet index in segment
  int segn = 0; // model segment number
  int nseg = 0; // model segment total
  logic [7:0] exp[$]; // expected octets
  drmf_pkg::drmf_elem_t elq[$]; // elements to offer
  always #2.5 core_clk_i = ~core_clk_i;
  drmf_framer DUT (.core_clk_i(core_clk_i), .reset_i(reset_i), .start_i(start_i),
    .cfg_i(cfg_i), .seg_len_i(seg_len_i), .elem_valid_i(elem_valid_i),
    .elem_ready_o(elem_ready_o), .elem_i(elem_i), .out_valid_o(out_valid_o),
    .out_ready_i(out_ready_i), .out_o(out_o), .busy_o(busy_o), .error_o(error_o));
  drmf_sink u_sink (.core_clk_i(core_clk_i), .reset_i(reset_i), .stall_i(stall),
    .out_valid_i(out_valid_o), .oct_i(out_o), .out_ready_o(out_ready_i), .seg_cnt_o(seg_cnt));
  // element source: head of queue offered, popped on transfer
  always @(posedge core_clk_i) begin
    if (elem_valid_i && elem_ready_o) begin
      void'(elq.pop_front());
      acc++;
    end
    #1 elem_valid_i = elq.size() != 0;
    if (elq.size() != 0) elem_i = elq[0];
  end
  // every accepted octet against the model
  always @(posedge core_clk_i) begin
    if (out_valid_o && out_ready_i) begin
      if (exp.size() == 0) begin
        err_count++;
        $display("mismatch octet expected none seen %0h", out_o.data);
      end else begin
        e_d = exp.pop_front();
        e_l = exp.size() == 0;
        e_se = e_l || (seg_len_i != 0 && pos == seg_len_i - 1);
        `CHK("data", e_d, out_o.data)
        `CHK("last", e_l, out_o.last)
        `CHK("seg_end", e_se, out_o.seg_end)
        `CHK("seg_num", segn[7:0], out_o.seg_num)
        pos++;
        if (e_se) begin
          nseg++;
          pos = 0;
          segn = e_l ? 0 : segn + 1;
        end
      end
    end
  end
  task automatic el(input logic [7:0] id, input logic [15:0] w, input logic l);
    drmf_pkg::drmf_elem_t e;
    e = {l, id, w};
    elq.push_back(e);
  endtask
  // wait until the previous message has drained
  task automatic idle();
    int n;
    n = 0;
    @(posedge core_clk_i);
    while ((exp.size() != 0 || busy_o !== 1'b0) && n < 5000) begin
      @(posedge core_clk_i);
      n++;
    end
    `CHK("drain", 0, exp.size())
    #1;
  endtask
  task automatic go(input drmf_pkg::drmf_cfg_t c, input string nm);
    cfg_i = c;
    start_i = 1'b1;
    @(posedge core_clk_i);
    #1 start_i = 1'b0;
    idle();
    $display("test %s done, checks %0d", nm, check_count);
  endtask
  task automatic backup(input int len);
    drmf_pkg::drmf_cfg_t c;
    logic [7:0] id;
    c = '0;
    c.src_seq = 16'($random(seed));
    acc = 0;
    exp.push_back(c.src_seq[15:8]);
    exp.push_back(c.src_seq[7:0]);
    for (int i = 0; i < len; i++) begin
      id = 8'($random(seed));
      el(id, {8'h00, id}, i == len - 1);
      exp.push_back(id);
    end
    repeat (24) @(posedge core_clk_i);
    `CHK("fifo fill", 16, acc)
    `CHK("elem_ready", 1'b0, elem_ready_o)
    #1 go(c, "backup");
  endtask
  task automatic routing(input int m, n, k, input logic sec, scp, zr);
    drmf_pkg::drmf_cfg_t c;
    logic [7:0] id;
    logic [15:0] w;
    c = '0;
    c.routing = 1'b1;
    c.secure = sec;
    c.sc_present = scp;
    c.ack_count = m[7:0];
    c.rec_count = n[7:0];
    c.res_count = k[7:0];
    c.sc_id = 8'($random(seed));
    c.sc_registration_identifier = {16'($random(seed)), 32'($random(seed))};
    id = 8'($random(seed));
    seg_len_i = {13'h0000, id[2:0]};
    exp.push_back(c.ack_count);
    repeat (m) begin
      id = 8'($random(seed));
      w = 16'($random(seed));
      el(id, w, 1'b0);
      exp.push_back(id);
      exp.push_back(w[15:8]);
      exp.push_back(w[7:0]);
    end
    exp.push_back(c.rec_count);
    repeat (n) begin
      id = 8'($random(seed));
      w = zr ? 16'h0000 : 16'h0001 + {14'h0000, id[7:6]};
      el(id, w, 1'b0);
      if (!zr) exp.push_back(id);
      if (!zr) exp.push_back(w[15:8]);
      if (!zr) exp.push_back(w[7:0]);
      repeat (w) begin
        id = 8'($random(seed));
        el(id, {8'h00, id}, 1'b0);
        exp.push_back(id);
      end
    end
    exp.push_back(c.res_count);
    repeat (k) begin
      id = 8'($random(seed));
      el(id, 16'h0000, 1'b0);
      exp.push_back(id);
    end
    if (sec) exp.push_back(scp ? c.sc_id : 8'h00);
    for (int i = 5; sec && i >= 0; i--) exp.push_back(scp ? c.sc_registration_identifier[i*8 +: 8] : 8'h00);
    go(c, "routing");
  endtask
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  // watchdog against a hang
  initial begin
    #200000;
    err_count++;
    $display("mismatch watchdog expected done seen hang");
    end_of_test();
  end
  initial begin
    repeat (20) @(posedge core_clk_i);
    #1 reset_i = 1'b0;
    backup(20);
    routing(0, 1, 0, 1'b1, 1'b0, 1'b1);
    `CHK("error", 1'b1, error_o)
    stall = 1'b1;
    repeat (6) begin
      routing({$random(seed)} % 4, 1 + {$random(seed)} % 3, {$random(seed)} % 4,
        1'($random(seed)), 1'b1, 1'b0);
    end
    `CHK("error", 1'b0, error_o)
    routing(0, 0, 0, 1'b0, 1'b0, 1'b0);
    `CHK("segments", nseg[15:0], seg_cnt)
    end_of_test();
  end
endmodule
`default_nettype wire
